// [rptis_pkg.sv]
// Package: register map, field layout and reset values of the Rp threshold block
package rptis_pkg;

  // ****************************************************************
  // Register indices; each register is one word at four times its index
  // ****************************************************************
  localparam logic [7:0] RPTIS_IDX_UPPER_LOW = 8'h06;
  localparam logic [7:0] RPTIS_IDX_UPPER_HIGH = 8'h07;
  localparam logic [7:0] RPTIS_IDX_LOWER_LOW = 8'h08;
  localparam logic [7:0] RPTIS_IDX_LOWER_HIGH = 8'h09;
  localparam logic [7:0] RPTIS_IDX_INT_SELECT = 8'h0a;
  localparam logic [7:0] RPTIS_IDX_IRQ_STATUS = 8'h0b;
  localparam logic [7:0] RPTIS_IDX_IRQ_MASK = 8'h0c;
  localparam logic [7:0] RPTIS_IDX_FLAGS = 8'h0d;

  // ****************************************************************
  // Reset values and fields
  // ****************************************************************
  localparam logic [7:0] RPTIS_BYTE_RESET = 8'h00;
  localparam logic [7:0] RPTIS_SELECT_RESET = 8'h00;
  localparam int RPTIS_ROUTE_BIT = 7;
  localparam int RPTIS_FUNC_MSB = 5;
  localparam logic [15:0] RPTIS_BYTE_WEIGHT = 16'h0100;
  localparam logic [5:0] RPTIS_FUNC_NONE = 6'h00;
  localparam logic [5:0] RPTIS_FUNC_RES_LATCH = 6'h01;
  localparam logic [5:0] RPTIS_FUNC_RES_HYST = 6'h02;
  localparam logic [5:0] RPTIS_FUNC_COMB_READY = 6'h04;
  localparam logic [5:0] RPTIS_FUNC_IND_LATCH = 6'h08;
  localparam logic [5:0] RPTIS_FUNC_IND_HYST = 6'h10;
  localparam logic [5:0] RPTIS_FUNC_HR_READY = 6'h20;
  // Status bits: 0 res high, 1 res low, 2 selected source rose
  localparam int RPTIS_STATUS_WIDTH = 3;

  // Conversion result from the cores, with its strobe
  typedef struct packed {
    logic valid;
    logic [15:0] value;
  } rptis_result_t;

  // Inductance-side events from the wider device
  typedef struct packed {
    logic hr_ready;
    logic comb_ready;
    logic ind_hyst;
    logic ind_latch;
  } rptis_ind_events_t;

endpackage : rptis_pkg

// [rptis_top.sv]
// Rp threshold compare and interrupt-source select with AHB-Lite registers
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps

// Functional notes
// - Upper threshold equals high byte times 256 plus low byte.
// - Result above upper threshold raises the resistive high flag.
// - Upper low byte is buffered until the upper high byte write.
// - Lower threshold equals high byte times 256 plus low byte.
// - Result below lower threshold raises the resistive low flag.
// - Lower low byte is buffered until the lower high byte write.
// - Threshold and select registers accept writes at any time.
// - Select bit 7 routes the interrupt onto the data-out pin.
// - Chosen source reaches data-out only when routing bit is one.
// - Codes 0x20 and 0x04 report the two data-ready events.
// - Codes 0x10 and 0x08 report inductance compares.
// - Code 0x02 is resistive hysteresis, 0x01 latched high compare.
// - Code zero gives no interrupt; other codes are reserved.
module rptis_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Conversion result and inductance-side events
  input wire rptis_pkg::rptis_result_t res_conversion_result_i,
  input wire rptis_pkg::rptis_ind_events_t ind_events_i,
  // Outputs
  output logic interrupt_output_o,
  output logic dataout_irq_o,
  output logic dataout_irq_oe_o,
  output logic irq_o
);

  // ****************************************************************
  // Bus capture
  // ****************************************************************
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [7:0] upper_low_buf;
  logic [7:0] upper_high;
  logic [7:0] lower_low_buf;
  logic [7:0] lower_high;
  logic [15:0] res_upper_threshold;
  logic [15:0] res_lower_threshold;
  logic [7:0] interrupt_select;
  logic [rptis_pkg::RPTIS_STATUS_WIDTH-1:0] status;
  logic [rptis_pkg::RPTIS_STATUS_WIDTH-1:0] mask;
  logic res_high_flag;
  logic res_low_flag;
  logic res_latch;
  logic res_hyst;
  logic sel_level;
  logic sel_prev;
  logic [rptis_pkg::RPTIS_STATUS_WIDTH-1:0] events;
  logic bus_take;

  assign bus_take = hsel_i && hready_i && htrans_i[1];

  // One register per word, so the index drops the byte lane bits
  function automatic logic [7:0] reg_index(input logic [31:0] addr);
    reg_index = addr[9:2];
  endfunction : reg_index

  // Write address held into the data phase
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= bus_take && hwrite_i;
      wr_addr <= reg_index(haddr_i);
    end
  end

  // Always zero wait states and OKAY
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  // ****************************************************************
  // Threshold registers
  // ****************************************************************
  function automatic logic [15:0] join_bytes(input logic [7:0] hi,
                                             input logic [7:0] lo);
    join_bytes = 16'(hi * rptis_pkg::RPTIS_BYTE_WEIGHT) + {8'h00, lo};
  endfunction : join_bytes

  // Low bytes only buffer; active value loads on the high byte write
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      upper_low_buf <= rptis_pkg::RPTIS_BYTE_RESET;
      upper_high <= rptis_pkg::RPTIS_BYTE_RESET;
      lower_low_buf <= rptis_pkg::RPTIS_BYTE_RESET;
      lower_high <= rptis_pkg::RPTIS_BYTE_RESET;
      res_upper_threshold <= {rptis_pkg::RPTIS_BYTE_RESET,
                              rptis_pkg::RPTIS_BYTE_RESET};
      res_lower_threshold <= {rptis_pkg::RPTIS_BYTE_RESET,
                              rptis_pkg::RPTIS_BYTE_RESET};
    end else if (wr_pend) begin
      unique case (wr_addr)
        rptis_pkg::RPTIS_IDX_UPPER_LOW: upper_low_buf <= hwdata_i[7:0];
        rptis_pkg::RPTIS_IDX_UPPER_HIGH: begin
          upper_high <= hwdata_i[7:0];
          res_upper_threshold <= join_bytes(hwdata_i[7:0],
                                            upper_low_buf);
        end
        rptis_pkg::RPTIS_IDX_LOWER_LOW: lower_low_buf <= hwdata_i[7:0];
        rptis_pkg::RPTIS_IDX_LOWER_HIGH: begin
          lower_high <= hwdata_i[7:0];
          res_lower_threshold <= join_bytes(hwdata_i[7:0],
                                            lower_low_buf);
        end
        default: ;
      endcase
    end
  end

  // Select and mask registers; reserved bit 6 kept at zero
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      interrupt_select <= rptis_pkg::RPTIS_SELECT_RESET;
      mask <= '0;
    end else if (wr_pend) begin
      if (wr_addr == rptis_pkg::RPTIS_IDX_INT_SELECT) begin
        interrupt_select <= {hwdata_i[7], 1'b0, hwdata_i[5:0]};
      end
      if (wr_addr == rptis_pkg::RPTIS_IDX_IRQ_MASK) begin
        mask <= hwdata_i[rptis_pkg::RPTIS_STATUS_WIDTH-1:0];
      end
    end
  end

  // ****************************************************************
  // Compare logic
  // ****************************************************************
  // Flags follow each new result
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      res_high_flag <= 1'b0;
      res_low_flag <= 1'b0;
    end else if (res_conversion_result_i.valid) begin
      res_high_flag <= res_conversion_result_i.value
                       > res_upper_threshold;
      res_low_flag <= res_conversion_result_i.value
                      < res_lower_threshold;
    end
  end

  // Latched compare holds until the function code is rewritten
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      res_latch <= 1'b0;
    end else if (wr_pend && wr_addr == rptis_pkg::RPTIS_IDX_INT_SELECT) begin
      res_latch <= 1'b0;
    end else if (res_conversion_result_i.valid &&
                 res_conversion_result_i.value > res_upper_threshold) begin
      res_latch <= 1'b1;
    end
  end

  // Hysteresis: set above upper, clear below lower
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      res_hyst <= 1'b0;
    end else if (res_conversion_result_i.valid) begin
      if (res_conversion_result_i.value > res_upper_threshold) begin
        res_hyst <= 1'b1;
      end else if (res_conversion_result_i.value
                   < res_lower_threshold) begin
        res_hyst <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Source select and outputs
  // ****************************************************************
  // Reserved codes give no output, like code zero
  always_comb begin
    unique case (interrupt_select[rptis_pkg::RPTIS_FUNC_MSB:0])
      rptis_pkg::RPTIS_FUNC_HR_READY: sel_level = ind_events_i.hr_ready;
      rptis_pkg::RPTIS_FUNC_COMB_READY:
        sel_level = ind_events_i.comb_ready;
      rptis_pkg::RPTIS_FUNC_IND_HYST: sel_level = ind_events_i.ind_hyst;
      rptis_pkg::RPTIS_FUNC_IND_LATCH:
        sel_level = ind_events_i.ind_latch;
      rptis_pkg::RPTIS_FUNC_RES_HYST: sel_level = res_hyst;
      rptis_pkg::RPTIS_FUNC_RES_LATCH: sel_level = res_latch;
      default: sel_level = 1'b0;
    endcase
  end

  // Registered outputs; the data-out pin is driven only when routed
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      interrupt_output_o <= 1'b0;
      dataout_irq_o <= 1'b0;
      dataout_irq_oe_o <= 1'b0;
      sel_prev <= 1'b0;
    end else begin
      interrupt_output_o <= sel_level;
      dataout_irq_oe_o <= interrupt_select[rptis_pkg::RPTIS_ROUTE_BIT];
      dataout_irq_o <= sel_level &&
                       interrupt_select[rptis_pkg::RPTIS_ROUTE_BIT];
      sel_prev <= sel_level;
    end
  end

  // ****************************************************************
  // Sticky status, write one to clear; set wins
  // ****************************************************************
  assign events = {sel_level && !sel_prev,
                   res_conversion_result_i.valid &&
                   res_conversion_result_i.value < res_lower_threshold,
                   res_conversion_result_i.valid &&
                   res_conversion_result_i.value > res_upper_threshold};

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      status <= '0;
    end else if (wr_pend && wr_addr == rptis_pkg::RPTIS_IDX_IRQ_STATUS) begin
      status <= (status & ~hwdata_i[rptis_pkg::RPTIS_STATUS_WIDTH-1:0])
                | events;
    end else begin
      status <= status | events;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status & mask);
    end
  end

  // ****************************************************************
  // Read data, registered in the data phase
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (bus_take && !hwrite_i) begin
      unique case (reg_index(haddr_i))
        rptis_pkg::RPTIS_IDX_UPPER_LOW: hrdata_o <= {24'h0, upper_low_buf};
        rptis_pkg::RPTIS_IDX_UPPER_HIGH: hrdata_o <= {24'h0, upper_high};
        rptis_pkg::RPTIS_IDX_LOWER_LOW: hrdata_o <= {24'h0, lower_low_buf};
        rptis_pkg::RPTIS_IDX_LOWER_HIGH: hrdata_o <= {24'h0, lower_high};
        rptis_pkg::RPTIS_IDX_INT_SELECT:
          hrdata_o <= {24'h0, interrupt_select};
        rptis_pkg::RPTIS_IDX_IRQ_STATUS: hrdata_o <= {29'h0, status};
        rptis_pkg::RPTIS_IDX_IRQ_MASK: hrdata_o <= {29'h0, mask};
        rptis_pkg::RPTIS_IDX_FLAGS:
          hrdata_o <= {29'h0, res_hyst, res_low_flag, res_high_flag};
        default: hrdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_upper_load: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    wr_pend && wr_addr == rptis_pkg::RPTIS_IDX_UPPER_HIGH |=>
    res_upper_threshold == {$past(hwdata_i[7:0]), $past(upper_low_buf)})
    else $error("upper threshold not loaded");
  chk_high_flag: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    res_conversion_result_i.valid |=> res_high_flag ==
    ($past(res_conversion_result_i.value) > $past(res_upper_threshold)))
    else $error("high flag wrong");
  chk_upper_hold: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    !(wr_pend && wr_addr == rptis_pkg::RPTIS_IDX_UPPER_HIGH) |=>
    $stable(res_upper_threshold))
    else $error("upper threshold changed early");
  chk_upper_buffer: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    wr_pend && wr_addr == rptis_pkg::RPTIS_IDX_UPPER_LOW |=>
    upper_low_buf == $past(hwdata_i[7:0]))
    else $error("upper low byte not buffered");
  chk_lower_load: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    wr_pend && wr_addr == rptis_pkg::RPTIS_IDX_LOWER_HIGH |=>
    res_lower_threshold == {$past(hwdata_i[7:0]), $past(lower_low_buf)})
    else $error("lower threshold not loaded");
  chk_low_flag: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    res_conversion_result_i.valid |=> res_low_flag ==
    ($past(res_conversion_result_i.value) < $past(res_lower_threshold)))
    else $error("low flag wrong");
  chk_lower_hold: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    !(wr_pend && wr_addr == rptis_pkg::RPTIS_IDX_LOWER_HIGH) |=>
    $stable(res_lower_threshold))
    else $error("lower threshold changed early");
  chk_lower_buffer: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    wr_pend && wr_addr == rptis_pkg::RPTIS_IDX_LOWER_LOW |=>
    lower_low_buf == $past(hwdata_i[7:0]))
    else $error("lower low byte not buffered");
  chk_select_write: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    wr_pend && wr_addr == rptis_pkg::RPTIS_IDX_INT_SELECT |=>
    interrupt_select == {$past(hwdata_i[7]), 1'b0, $past(hwdata_i[5:0])})
    else $error("select write not taken");
  chk_oe_route: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    1'b1 |=> dataout_irq_oe_o == $past(interrupt_select[7]))
    else $error("data-out enable not following route bit");
  chk_route_off: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    !interrupt_select[7] |=> !dataout_irq_o && !dataout_irq_oe_o)
    else $error("data-out driven while unrouted");
  chk_route_on: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    interrupt_select[7] |=> dataout_irq_o == $past(sel_level))
    else $error("routed source missing");
  chk_hr_source: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    interrupt_select[5:0] == rptis_pkg::RPTIS_FUNC_HR_READY |=>
    interrupt_output_o == $past(ind_events_i.hr_ready))
    else $error("high-res ready source not selected");
  chk_comb_source: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    interrupt_select[5:0] == rptis_pkg::RPTIS_FUNC_COMB_READY |=>
    interrupt_output_o == $past(ind_events_i.comb_ready))
    else $error("combined ready source not selected");
  chk_ind_hyst: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    interrupt_select[5:0] == rptis_pkg::RPTIS_FUNC_IND_HYST |=>
    interrupt_output_o == $past(ind_events_i.ind_hyst))
    else $error("inductance hysteresis source not selected");
  chk_ind_latch: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    interrupt_select[5:0] == rptis_pkg::RPTIS_FUNC_IND_LATCH |=>
    interrupt_output_o == $past(ind_events_i.ind_latch))
    else $error("inductance latch source not selected");
  chk_latch_set: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    res_conversion_result_i.valid &&
    res_conversion_result_i.value > res_upper_threshold &&
    !(wr_pend && wr_addr == rptis_pkg::RPTIS_IDX_INT_SELECT) |=> res_latch)
    else $error("latched compare not set");
  chk_latch_clear: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    wr_pend && wr_addr == rptis_pkg::RPTIS_IDX_INT_SELECT |=> !res_latch)
    else $error("latched compare not cleared");
  chk_code_none: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    interrupt_select[5:0] == rptis_pkg::RPTIS_FUNC_NONE |=>
    !interrupt_output_o)
    else $error("interrupt with code zero");
  chk_hyst_set: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    res_conversion_result_i.valid &&
    res_conversion_result_i.value > res_upper_threshold |=> res_hyst)
    else $error("hysteresis not set");
  chk_hyst_keep: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    res_hyst && !(res_conversion_result_i.valid &&
    res_conversion_result_i.value < res_lower_threshold) |=> res_hyst)
    else $error("hysteresis dropped early");
  chk_status_set: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    |events |=> (status & $past(events)) == $past(events))
    else $error("status event lost");

endmodule : rptis_top

// [rptis_host.sv]
// Host model: AHB-Lite master that reaches the threshold block registers
`timescale 1ns/1ps
module rptis_host (
  // Clock
  input wire logic clk_i,
  // Bus answer
  input wire logic hready_i,
  input wire logic [31:0] hrdata_i,
  // Bus request
  output logic hsel_o,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [2:0] hsize_o,
  output logic [31:0] hwdata_o
);
  // Idle bus from time zero
  initial begin
    hsel_o = 1'b0;
    haddr_o = 32'h0;
    htrans_o = 2'b00;
    hwrite_o = 1'b0;
    hsize_o = 3'b010;
    hwdata_o = 32'h0;
  end

  // ****************************************************************
  // Single word transfer, entered just after a rising edge
  // ****************************************************************
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    hsel_o <= 1'b1;
    haddr_o <= {22'h0, a, 2'b00}; // Index a, byte address four times it
    htrans_o <= 2'b10;
    hwrite_o <= wr;
    hsize_o <= 3'b010;
    @(posedge clk_i);
    while (hready_i !== 1'b1) @(posedge clk_i);
    hsel_o <= 1'b0;
    htrans_o <= 2'b00;
    // Reads leave stale data toggling so it is never mistaken
    hwdata_o <= wr ? wd : ~hwdata_o;
    @(posedge clk_i);
    while (hready_i !== 1'b1) @(posedge clk_i);
    rd = hrdata_i;
  endtask : xfer

  // Both bytes, low first, so the pair loads as one threshold
  task automatic set_pair(input logic [7:0] a, input logic [15:0] v);
    logic [31:0] junk;
    xfer(1'b1, a, {24'h0, v[7:0]}, junk);
    xfer(1'b1, a + 8'h01, {24'h0, v[15:8]}, junk);
  endtask : set_pair
endmodule : rptis_host

// [rp_threshold_interrupt_select_tb.sv]
// Testbench: thresholds, source select, routing and interrupt status
`timescale 1ns/1ps
`define CHK(n, e, s) begin \
  cmp_count++; \
  if ((s) !== (e)) begin \
    fail_count++; \
    $display("Error %s exp %h got %h", n, e, s); \
  end \
end
module rp_threshold_interrupt_select_tb;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic hsel, hwrite, hready, hresp, irq, iout, dout, doe;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, d;
  rptis_pkg::rptis_result_t res = '0;
  rptis_pkg::rptis_ind_events_t ind = '0;
  int fail_count = 0;
  int cmp_count = 0;

  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;

  rptis_host host (.clk_i(clk_i), .hready_i(hready), .hrdata_i(hrdata),
    .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans),
    .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));

  rptis_top dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .res_conversion_result_i(res), .ind_events_i(ind),
    .interrupt_output_o(iout), .dataout_irq_o(dout),
    .dataout_irq_oe_o(doe), .irq_o(irq));

  // ****************************************************************
  // Shared helpers
  // ****************************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    host.xfer(1'b1, a, {24'h0, v}, d);
  endtask : wr
  task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e);
    host.xfer(1'b0, a, 32'h0, d);
    `CHK(n, {24'h0, e}, d)
    `CHK("hresp", 1'b0, hresp)
  endtask : rd
  // One result strobe, then time for flags and output to settle
  task automatic pulse(input logic [15:0] v);
    res <= {1'b1, v};
    @(posedge clk_i);
    res <= '0;
    cyc(3);
  endtask : pulse
  task automatic flag(input logic [15:0] v, input int b, input logic e);
    pulse(v);
    host.xfer(1'b0, 8'h0d, 32'h0, d);
    `CHK("flag", e, d[b])
  endtask : flag
  task automatic outs(input logic o, input logic p, input logic e);
    `CHK("irq line", o, iout)
    `CHK("dataout", p, dout)
    `CHK("dataout oe", e, doe)
  endtask : outs

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    for (int a = 6; a <= 10; a++) rd("reset", 8'(a), 8'h00);
    rd("unmapped", 8'h30, 8'h00);
    outs(1'b0, 1'b0, 1'b0);
  endtask : t_reset
  task automatic t_upper;
    host.set_pair(8'h06, 16'h1000);
    wr(8'h06, 8'hff);
    flag(16'h1001, 0, 1'b1);
    rd("upper low buf", 8'h06, 8'hff);
    wr(8'h07, 8'h10);
    flag(16'h1001, 0, 1'b0);
    flag(16'h10ff, 0, 1'b0);
    flag(16'h1100, 0, 1'b1);
  endtask : t_upper
  task automatic t_lower;
    host.set_pair(8'h08, 16'h0200);
    wr(8'h08, 8'h80);
    flag(16'h0201, 1, 1'b0);
    wr(8'h09, 8'h02);
    flag(16'h027f, 1, 1'b1);
    flag(16'h0280, 1, 1'b0);
  endtask : t_lower
  // Inductance-side codes map onto event bits 3 down to 0
  task automatic t_ind;
    logic [5:0] code [4] = '{6'h20, 6'h04, 6'h10, 6'h08};
    for (int i = 0; i < 4; i++) begin
      wr(8'h0a, {2'b10, code[i]});
      ind <= 4'b1000 >> i;
      cyc(3);
      outs(1'b1, 1'b1, 1'b1);
      ind <= '0;
      cyc(3);
      outs(1'b0, 1'b0, 1'b1);
    end
  endtask : t_ind
  task automatic t_route;
    wr(8'h0a, 8'h20);
    ind <= 4'b1000;
    cyc(3);
    outs(1'b1, 1'b0, 1'b0);
    wr(8'h0a, 8'h82);
    ind <= 4'hf;
    cyc(3);
    outs(1'b0, 1'b0, 1'b1);
    rd("select", 8'h0a, 8'h82);
    wr(8'h0a, 8'h80);
    cyc(2);
    outs(1'b0, 1'b0, 1'b1);
    ind <= '0;
  endtask : t_route
  // Thresholds now: upper 0x10ff, lower 0x0280
  task automatic t_res;
    logic [15:0] v [5] = '{16'h0100, 16'h1000, 16'h2000, 16'h1000, 16'h0100};
    logic e [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    wr(8'h0a, 8'h81);
    pulse(16'h2000);
    pulse(16'h1000);
    outs(1'b1, 1'b1, 1'b1);
    wr(8'h0a, 8'h81);
    cyc(2);
    outs(1'b0, 1'b0, 1'b1);
    wr(8'h0a, 8'h82);
    for (int i = 0; i < 5; i++) begin
      pulse(v[i]);
      `CHK("hyst out", e[i], iout)
    end
  endtask : t_res
  task automatic t_irq;
    wr(8'h0a, 8'h00);
    wr(8'h0b, 8'h07);
    rd("status clr", 8'h0b, 8'h00);
    wr(8'h0c, 8'h01);
    pulse(16'h2000);
    `CHK("irq", 1'b1, irq)
    rd("status", 8'h0b, 8'h01);
    wr(8'h0c, 8'h00);
    pulse(16'h0100);
    `CHK("irq masked", 1'b0, irq)
    wr(8'h0c, 8'h02);
    cyc(2);
    `CHK("irq low", 1'b1, irq)
    wr(8'h0b, 8'h03);
    cyc(2);
    `CHK("irq cleared", 1'b0, irq)
    rd("status end", 8'h0b, 8'h00);
    ind <= 4'b1000;
    wr(8'h0a, 8'h20);
    cyc(1);
    rd("status rise", 8'h0b, 8'h04);
    ind <= '0;
  endtask : t_irq

  // Verdict and end of run
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  // Main sequence after 3 cycles of reset
  initial begin
    cyc(3);
    reset_n_i <= 1'b1;
    t_reset();
    t_upper();
    t_lower();
    t_ind();
    t_route();
    t_res();
    t_irq();
    close_out();
  end

  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #75000;
    fail_count++;
    close_out();
  end
endmodule : rp_threshold_interrupt_select_tb
